// ===== src/stc_map.svh
// register offsets, field positions, reset values and timing counts for the timer/counter
`ifndef STC_MAP_SVH
`define STC_MAP_SVH
`define STC_ADDR_CONTROL     4'h0
`define STC_ADDR_LOW         4'h1
`define STC_ADDR_HIGH        4'h2
`define STC_ADDR_STATUS      4'h3
`define STC_CONTROL_RESET    8'h00
`define STC_BIT_RUN          0
`define STC_BIT_SOURCE       1
`define STC_BIT_SYNC_BYPASS  2
`define STC_BIT_OSC_ENABLE   3
`define STC_BIT_DIV_LO       4
`define STC_BIT_DIV_HI       5
`define STC_BIT_SYSCLK_OSC   6
`define STC_BIT_WIDE         7
`define STC_BIT_FLAG         0
`define STC_CTRL_WMASK       8'hbf
`define STC_INSTR_DIV        2'h3
`define STC_COUNT_MAX        16'hffff
`endif

// ===== src/stc_pkg.sv
// types shared by the timer/counter
package stc_pkg;
  typedef logic [7:0]  stc_byte_t;
  typedef logic [15:0] stc_count_t;
endpackage

// ===== src/stc_timer.sv
// sixteen-bit timer/counter with prescaler, buffered wide access and oscillator control
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "stc_map.svh"

//Contract
//- counter increments only while counter_run is set, else holds
//- source 0 counts instruction cycles, source 1 counts external rising edges
//- external source advances on input pin or enabled oscillator rising edges
//- ext_sync_bypass 0 synchronises, 1 skips it; ignored on internal source
//- input_divide_sel divides by 1, 2, 4 or 8
//- lowpower_osc_enable turns oscillator on; clear turns it fully off
//- status bit reads 1 while system clock comes from oscillator
//- wide_access_sel selects atomic 16-bit access, else two byte access
//- oscillator enabled disables pin logic; directions ignored, pins read zero
//- wide mode: low byte read copies live high byte into buffer
//- wide mode: high write fills buffer; low write loads both bytes
//- wide mode: live high byte reachable only through the buffer
//- low byte write clears prescaler; high byte write leaves it
//- enabled oscillator keeps running in every power-managed mode
//- control register holds all control bits and resets to zero
//- counter rolls from all ones to zero and sets overflow_flag
//- compare special event resets counter except in asynchronous mode
//- software counter write beats a coincident special event reset
module stc_timer (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // register port
  input  wire logic [3:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  output logic      [7:0]       rdata,
  // count sources
  input  wire logic             ext_count_input,
  input  wire logic             osc_clk,
  input  wire logic             sysclk_on_osc,
  input  wire logic             special_event,
  // oscillator pins and port
  input  wire logic [1:0]       port_c_direction,
  input  wire logic [1:0]       pin_in,
  output logic      [1:0]       pin_read,
  output logic      [1:0]       pin_oe,
  output logic                  osc_power_on,
  // status
  output logic                  overflow_flag,
  output logic      [15:0]      count_value
);

  stc_pkg::stc_byte_t  control, next_control;
  stc_pkg::stc_count_t count, next_count;
  stc_pkg::stc_byte_t  count_high_buffer, next_count_high_buffer;
  logic [2:0] prescale, next_prescale;
  logic [1:0] instr_div, next_instr_div;
  logic       sync_a, sync_b, edge_prev, next_edge_prev;
  logic       async_prev, next_async_prev;
  logic       next_flag, status_bit;
  logic [7:0] next_rdata;
  wire logic [1:0] next_pin_read, next_pin_oe;

  logic run, src_ext, bypass, osc_en, wide;
  logic [1:0] div_sel;
  logic raw_src, tick, wr_low, wr_high, rd_low, wr_ctrl, inc_ok;
  logic [2:0] div_mask;

  assign run     = control[`STC_BIT_RUN];
  assign src_ext = control[`STC_BIT_SOURCE];
  assign bypass  = control[`STC_BIT_SYNC_BYPASS];
  assign osc_en  = control[`STC_BIT_OSC_ENABLE];
  assign wide    = control[`STC_BIT_WIDE];
  assign div_sel = control[`STC_BIT_DIV_HI:`STC_BIT_DIV_LO];
  assign wr_low  = wr_en && (addr == `STC_ADDR_LOW);
  assign wr_high = wr_en && (addr == `STC_ADDR_HIGH);
  assign wr_ctrl = wr_en && (addr == `STC_ADDR_CONTROL);
  assign rd_low  = rd_en && (addr == `STC_ADDR_LOW);
  assign raw_src = ext_count_input | (osc_en & osc_clk);

  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw_src;
      sync_b <= sync_a;
    end
  end

  // source edge selection and prescaler tick
  always_comb begin
    next_edge_prev  = sync_b;
    next_async_prev = raw_src;
    next_instr_div  = instr_div + 2'h1;
    tick            = 1'b0;
    if (!src_ext) begin
      tick = (instr_div == `STC_INSTR_DIV);
    end else if (bypass) begin
      // unsynchronised path, sampled straight from the pins
      tick = raw_src & ~async_prev;
    end else begin
      tick = sync_b & ~edge_prev;
    end
    case (div_sel)
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      2'h3:    div_mask = 3'h7;
      default: div_mask = 3'h0;
    endcase
    next_prescale = prescale;
    inc_ok        = 1'b0;
    if (run && tick) begin
      next_prescale = (prescale + 3'h1) & div_mask;
      inc_ok        = ((prescale & div_mask) == div_mask);
    end
    if (wr_low) begin
      next_prescale = 3'h0;
    end
  end

  // counter, buffer, control and flag
  always_comb begin
    next_count             = count;
    next_count_high_buffer = count_high_buffer;
    next_control           = control;
    next_flag              = overflow_flag;
    if (inc_ok) begin
      next_count = count + 16'h0001;
      if (count == `STC_COUNT_MAX) begin
        next_flag = 1'b1;
      end
    end
    if (special_event && !(src_ext && bypass)) begin
      next_count = 16'h0000;
    end
    if (wr_ctrl) begin
      next_control = wdata & `STC_CTRL_WMASK;
    end
    if (wr_en && addr == `STC_ADDR_STATUS && wdata[`STC_BIT_FLAG]) begin
      next_flag = 1'b0;
    end
    if (inc_ok && count == `STC_COUNT_MAX) begin
      next_flag = 1'b1; // set wins over clear
    end
    if (wide) begin
      if (rd_low) begin
        next_count_high_buffer = count[15:8];
      end
      if (wr_high) begin
        next_count_high_buffer = wdata;
      end
      if (wr_low) begin
        next_count = {count_high_buffer, wdata};
      end
    end else begin
      if (wr_high) begin
        next_count = {wdata, count[7:0]};
      end
      if (wr_low) begin
        next_count = {count[15:8], wdata};
      end
    end
  end

  // read mux and pin logic
  always_comb begin
    status_bit = sysclk_on_osc;
    next_rdata = 8'h00;
    if (rd_en) begin
      case (addr)
        `STC_ADDR_CONTROL: begin
          next_rdata = control;
          next_rdata[`STC_BIT_SYSCLK_OSC] = status_bit;
        end
        `STC_ADDR_LOW:    next_rdata = count[7:0];
        `STC_ADDR_HIGH:   next_rdata = wide ? count_high_buffer : count[15:8];
        `STC_ADDR_STATUS: next_rdata = {7'h00, overflow_flag};
        default:          next_rdata = 8'h00;
      endcase
    end
  end

  // per-pin gating; both oscillator pins behave alike, so one loop serves them
  genvar pin_idx;
  generate
    for (pin_idx = 0; pin_idx < 2; pin_idx++) begin : g_pin
      // the oscillator owns the pin while enabled, so direction is ignored
      assign next_pin_read[pin_idx] = osc_en ? 1'b0 : pin_in[pin_idx];
      assign next_pin_oe[pin_idx]   = osc_en ? 1'b0 : ~port_c_direction[pin_idx];
    end
  endgenerate

  // state registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      control           <= `STC_CONTROL_RESET;
      count             <= 16'h0000;
      count_high_buffer <= 8'h00;
      prescale          <= 3'h0;
      instr_div         <= 2'h0;
      edge_prev         <= 1'b0;
      async_prev        <= 1'b0;
      overflow_flag     <= 1'b0;
      rdata             <= 8'h00;
      pin_read          <= 2'h0;
      pin_oe            <= 2'h0;
      osc_power_on      <= 1'b0;
      count_value       <= 16'h0000;
    end else begin
      control           <= next_control;
      count             <= next_count;
      count_high_buffer <= next_count_high_buffer;
      prescale          <= next_prescale;
      instr_div         <= next_instr_div;
      edge_prev         <= next_edge_prev;
      async_prev        <= next_async_prev;
      overflow_flag     <= next_flag;
      rdata             <= next_rdata;
      pin_read          <= next_pin_read;
      pin_oe            <= next_pin_oe;
      // power follows only the enable bit, not any sleep state
      osc_power_on      <= next_control[`STC_BIT_OSC_ENABLE];
      count_value       <= next_count;
    end
  end

  // checks
  AST_HOLD_WHEN_STOPPED: assert property (@(posedge clock) disable iff (!rst_n)
    (!run && !wr_en && !special_event) |=> (count == $past(count)))
    else $error("counter moved while stopped");

  AST_ROLLOVER_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
    (inc_ok && count == `STC_COUNT_MAX && !wr_en && !special_event)
      |=> (count == 16'h0000 && overflow_flag))
    else $error("rollover did not set flag");

  AST_WIDE_READ_COPY: assert property (@(posedge clock) disable iff (!rst_n)
    (wide && rd_low && !wr_en) |=> (count_high_buffer == $past(count[15:8])))
    else $error("low read did not copy high byte");

  AST_WIDE_HIGH_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    (wide && wr_high && !special_event && !inc_ok) |=> (count == $past(count)))
    else $error("buffered high write touched counter");

  AST_WIDE_LOW_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    (wide && wr_low) |=> (count == {$past(count_high_buffer), $past(wdata)}))
    else $error("low write did not load both bytes");

  AST_PRESCALE_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    wr_low |=> (prescale == 3'h0))
    else $error("low write left prescaler");

  AST_WRITE_WINS: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_low && special_event && !wide) |=> (count[7:0] == $past(wdata)))
    else $error("event beat software write");

  AST_PINS_DISABLED: assert property (@(posedge clock) disable iff (!rst_n)
    osc_en |=> (pin_read == 2'h0 && pin_oe == 2'h0))
    else $error("pins active with oscillator on");

  AST_BYTE_HIGH_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    (!wide && wr_high) |=> (count[15:8] == $past(wdata)))
    else $error("byte mode high write lost");

  AST_BYTE_LOW_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    (!wide && wr_low) |=> (count == {$past(count[15:8]), $past(wdata)}))
    else $error("byte mode low write touched high byte");

  AST_STATUS_READ: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_en && addr == `STC_ADDR_CONTROL)
      |=> (rdata[`STC_BIT_SYSCLK_OSC] == $past(sysclk_on_osc)))
    else $error("clock status bit wrong");

  AST_OSC_POWER: assert property (@(posedge clock) disable iff (!rst_n)
    wr_ctrl |=> (osc_power_on == $past(wdata[`STC_BIT_OSC_ENABLE])))
    else $error("oscillator power does not follow enable");

  AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (!rst_n)
    (overflow_flag && !(wr_en && addr == `STC_ADDR_STATUS && wdata[`STC_BIT_FLAG]))
      |=> overflow_flag)
    else $error("overflow flag dropped without a clear");

  AST_EVENT_RESET: assert property (@(posedge clock) disable iff (!rst_n)
    (special_event && !(src_ext && bypass) && !wr_low && !wr_high)
      |=> (count == 16'h0000))
    else $error("special event did not reset counter");

  AST_UNMAPPED_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_en && addr > `STC_ADDR_STATUS) |=> (control == $past(control)))
    else $error("unmapped write changed control");

  AST_ASYNC_EDGE: assert property (@(posedge clock) disable iff (!rst_n)
    (src_ext && bypass && run && div_sel == 2'h0 && raw_src && !async_prev && !wr_en)
      |=> (count == $past(count) + 16'h0001))
    else $error("asynchronous edge not counted");

  // synchronised edge: raw rise, two synchroniser stages, then one increment
  sequence seq_sync_rise;
    src_ext && !bypass && run && div_sel == 2'h0 && $rose(raw_src) && !wr_en;
  endsequence

  sequence seq_sync_settle;
    !wr_en ##1 (!wr_en && !special_event);
  endsequence

  AST_SYNC_DELAY: assert property (@(posedge clock) disable iff (!rst_n)
    seq_sync_rise ##1 seq_sync_settle |=> (count == $past(count) + 16'h0001))
    else $error("synchronised edge not counted after two stages");

  // a cycle in which nothing can touch the high byte buffer
  sequence seq_bus_quiet;
    !wr_en && !rd_low;
  endsequence

  // wide write pair: buffer fill, then a low write lands both bytes together
  sequence seq_buffer_fill;
    wide && wr_high;
  endsequence

  sequence seq_low_commit;
    wide && wr_low;
  endsequence

  AST_WIDE_WRITE_PAIR: assert property (@(posedge clock) disable iff (!rst_n)
    seq_buffer_fill ##1 seq_bus_quiet ##1 seq_low_commit |=> (count[15:8] == $past(wdata, 3)))
    else $error("paired wide write lost the buffered high byte");

  // wide read pair: low read snapshots, later high read returns that snapshot
  sequence seq_low_snapshot;
    wide && rd_low && !wr_en;
  endsequence

  sequence seq_high_fetch;
    wide && rd_en && addr == `STC_ADDR_HIGH;
  endsequence

  AST_WIDE_READ_PAIR: assert property (@(posedge clock) disable iff (!rst_n)
    seq_low_snapshot ##1 seq_bus_quiet ##1 seq_high_fetch
      |=> (rdata == $past(count[15:8], 3)))
    else $error("paired wide read did not return the snapshot");

endmodule

// ===== verification/stc_timer_tb.sv
// self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/1ps
`include "stc_map.svh"
module stc_timer_tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [7:0]  rdata;
  logic        ext_count_input = 1'b0;
  logic        osc_clk = 1'b0;
  logic        sysclk_on_osc = 1'b0;
  logic        special_event = 1'b0;
  logic [1:0]  port_c_direction = 2'h1;
  logic [1:0]  pin_in = 2'h2;
  logic [1:0]  pin_read;
  logic [1:0]  pin_oe;
  logic        osc_power_on;
  logic        overflow_flag;
  logic [15:0] count_value;
  logic [15:0] c0;
  int          fails = 0;
  int          tests_run = 0;

  // 8 ns period
  always #4 clock = ~clock;

  stc_timer i_stc_timer (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .ext_count_input(ext_count_input), .osc_clk(osc_clk),
    .sysclk_on_osc(sysclk_on_osc), .special_event(special_event),
    .port_c_direction(port_c_direction), .pin_in(pin_in),
    .pin_read(pin_read), .pin_oe(pin_oe), .osc_power_on(osc_power_on),
    .overflow_flag(overflow_flag), .count_value(count_value)
  );

  // compare and report
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask

  // span is a multiple of every prescale period, so the delta is exact
  task automatic rate(input logic [7:0] ctl, input int span, input logic [15:0] exp);
    wr(`STC_ADDR_CONTROL, ctl);
    repeat (40) @(posedge clock);
    #1;
    c0 = count_value;
    repeat (span) @(posedge clock);
    #1;
    chk("count rate", exp, count_value - c0);
  endtask

  // slow pulses leave room for the synchroniser delay
  task automatic edges(input logic [7:0] ctl, input bit use_osc, input int n);
    wr(`STC_ADDR_CONTROL, ctl);
    c0 = count_value;
    repeat (n) begin
      @(posedge clock);
      if (use_osc)
        osc_clk <= 1'b1;
      else
        ext_count_input <= 1'b1;
      repeat (4) @(posedge clock);
      osc_clk <= 1'b0;
      ext_count_input <= 1'b0;
      repeat (4) @(posedge clock);
    end
    #1;
    chk("edge count", 16'(n), count_value - c0);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    give_verdict;
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(`STC_ADDR_CONTROL, 8'h00, "control reset");
    chk("count reset", 16'h0000, count_value);
    wr(`STC_ADDR_CONTROL, 8'hff);
    rd(`STC_ADDR_CONTROL, 8'hbf, "control rw");
    @(posedge clock);
    sysclk_on_osc <= 1'b1;
    wr(`STC_ADDR_CONTROL, 8'h00);
    rd(`STC_ADDR_CONTROL, 8'h40, "clock status");
    @(posedge clock);
    sysclk_on_osc <= 1'b0;
    wr(`STC_ADDR_LOW, 8'h34);
    wr(`STC_ADDR_HIGH, 8'h12);
    repeat (20) @(posedge clock);
    #1;
    chk("byte load", 16'h1234, count_value);
    rd(`STC_ADDR_HIGH, 8'h12, "live high");
    for (int d = 0; d < 4; d++) begin
      rate({2'b00, 2'(d), 4'h1}, 64, 16'd16 >> d);
    end
    rate(8'h05, 64, 16'd16);
    rate(8'h00, 64, 16'd0);
    // rollover from all ones
    wr(`STC_ADDR_HIGH, 8'hff);
    wr(`STC_ADDR_LOW, 8'hfe);
    wr(`STC_ADDR_CONTROL, 8'h01);
    repeat (16) @(posedge clock);
    #1;
    chk("overflow", 16'h0001, {15'h0, overflow_flag});
    chk("wrapped high", 16'h0000, {8'h00, count_value[15:8]});
    wr(`STC_ADDR_CONTROL, 8'h80);
    rd(`STC_ADDR_STATUS, 8'h01, "status");
    wr(`STC_ADDR_STATUS, 8'h01);
    rd(`STC_ADDR_STATUS, 8'h00, "status clear");
    // buffered wide access
    c0 = count_value;
    wr(`STC_ADDR_HIGH, 8'hab);
    chk("buffer only", c0, count_value);
    wr(`STC_ADDR_LOW, 8'hcd);
    chk("wide load", 16'habcd, count_value);
    wr(`STC_ADDR_HIGH, 8'h55);
    rd(`STC_ADDR_HIGH, 8'h55, "buffer read");
    rd(`STC_ADDR_LOW, 8'hcd, "low read");
    rd(`STC_ADDR_HIGH, 8'hab, "latched high");
    // external sources
    edges(8'h03, 1'b0, 5);
    edges(8'h07, 1'b0, 5);
    wr(`STC_ADDR_CONTROL, 8'h08);
    repeat (32) @(posedge clock);
    edges(8'h0b, 1'b1, 5);
    chk("osc power", 16'h0001, {15'h0, osc_power_on});
    chk("pins gated", 16'h0000, {12'h0, pin_read, pin_oe});
    wr(`STC_ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge clock);
    #1;
    chk("osc off", 16'h0000, {15'h0, osc_power_on});
    chk("pins live", 16'h000a, {12'h0, pin_read, pin_oe});
    // special event, then coinciding with a low write
    wr(`STC_ADDR_HIGH, 8'h12);
    @(posedge clock);
    special_event <= 1'b1;
    @(posedge clock);
    special_event <= 1'b0;
    #1;
    chk("event reset", 16'h0000, count_value);
    wr(`STC_ADDR_HIGH, 8'h12);
    @(posedge clock);
    addr <= `STC_ADDR_LOW;
    wdata <= 8'h42;
    wr_en <= 1'b1;
    special_event <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    special_event <= 1'b0;
    #1;
    chk("write wins", 16'h1242, count_value);
    give_verdict;
  end
endmodule
